/* File: hw/dual_timer_pkg.sv */
// Purpose: shared constants and types for the dual 8-bit timer/event counter
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes: register addresses sit on the 16-bit cpu memory map
package dual_timer_pkg;
	// ==========================================================
	// register addresses
	localparam logic [15:0] ADDR_COUNT_ONE = 16'hFF10;
	localparam logic [15:0] ADDR_COUNT_TWO = 16'hFF11;
	localparam logic [15:0] ADDR_CMP_ONE = 16'hFF12;
	localparam logic [15:0] ADDR_CMP_TWO = 16'hFF13;
	localparam logic [15:0] ADDR_PORT_DIR = 16'hFF23;
	localparam logic [15:0] ADDR_CLK_SEL = 16'hFF41;
	localparam logic [15:0] ADDR_MODE_CTL = 16'hFF49;
	localparam logic [15:0] ADDR_OUT_CTL = 16'hFF4A;

	// ==========================================================
	// reset values
	localparam logic [7:0] RST_CLK_SEL = 8'h00;
	localparam logic [7:0] RST_MODE_CTL = 8'h00;
	localparam logic [7:0] RST_OUT_CTL = 8'h00;
	localparam logic [7:0] RST_PORT_DIR = 8'hFF;
	localparam logic [7:0] RST_COUNT = 8'h00;

	// ==========================================================
	// field positions
	localparam int MODE_ENABLE_ONE = 0;
	localparam int MODE_ENABLE_TWO = 1;
	localparam int MODE_CASCADE = 2;
	localparam int OUT_ENABLE_ONE = 0;
	localparam int OUT_INVERT_ONE = 1;
	localparam int OUT_LVL_RESET_ONE = 2;
	localparam int OUT_LVL_SET_ONE = 3;
	localparam int OUT_ENABLE_TWO = 4;
	localparam int OUT_INVERT_TWO = 5;
	localparam int OUT_LVL_RESET_TWO = 6;
	localparam int OUT_LVL_SET_TWO = 7;
	localparam int DIR_PIN_ONE = 1;
	localparam int DIR_PIN_TWO = 2;
	// write-only strobes read back as zero
	localparam logic [7:0] OUT_CTL_RD_MASK = 8'h33;

	// ==========================================================
	// clock select codes (one nibble per counter)
	localparam logic [3:0] CSEL_EDGE_FALL = 4'h0;
	localparam logic [3:0] CSEL_EDGE_RISE = 4'h1;
	localparam logic [3:0] CSEL_DIV_FIRST = 4'h6;
	localparam logic [3:0] CSEL_DIV_LAST = 4'hE;
	localparam logic [3:0] CSEL_DIV_TOP = 4'hF;
	localparam int PRESCALE_BITS = 11;
	localparam int DIV_TOP_EXP = 11;

	// ==========================================================
	// cpu memory access carrier
	typedef struct packed {
		logic [15:0] addr;
		logic rd;
		logic wr;
		logic word;
		logic bit_op;
		logic [2:0] bit_idx;
		logic bit_val;
		logic [15:0] wdata;
	} cpu_req_s;
endpackage

/* File: hw/fxx_prescaler.sv */
// Purpose: base-rate prescaler giving one-cycle taps fxx/2 to fxx/2^11
// Assumes: the reference clock is the oscillator frequency
// Notes: taps are combinational enables aligned to the reference clock
`timescale 1ns/1ps
module fxx_prescaler import dual_timer_pkg::*; #(
	parameter int BITS = PRESCALE_BITS
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// base rate select: 1 = full rate, 0 = half rate
	input wire logic i_osc_div_select,
	// tick k pulses once per 2^k base periods
	output logic [BITS:1] o_tick
);
	logic half_r;
	logic base_en;
	logic [BITS-1:0] div_r;

	// ==========================================================
	// base rate fxx as an enable
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			half_r <= 1'b0;
		end else begin
			half_r <= ~half_r;
		end
	end
	assign base_en = i_osc_div_select | half_r;

	// free-running divider, advances only on base-rate enables
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			div_r <= '0;
		end else if (base_en) begin
			div_r <= div_r + 1'b1;
		end
	end

	// ==========================================================
	// one tap per divider stage
	genvar k;
	generate
		for (k = 1; k <= BITS; k++) begin : g_tap
			assign o_tick[k] = base_en & (&div_r[k-1:0]);
		end
	endgenerate
endmodule // fxx_prescaler

/* File: hw/dual_timer.sv */
// Purpose: two 8-bit timer/event counters with compare, cascade and wave outputs
// Assumes: cpu accesses are synchronous one-cycle strobes on the 40 MHz clock
// Notes: compare registers are not reset; software stops timers before reconfiguring
//
// Function
// - match clears counter, raises channel interrupt
// - interval is compare value plus one
// - compare spans 00H-FFH, cascaded 0000H-FFFFH
// - compare written by byte only
// - compare contents undefined after reset
// - reset clears both counters
// - byte counter reads; cascaded 16-bit read
// - low nibble selects counter one clock
// - high nibble selects counter two clock
// - base rate fx or fx/2
// - clock select at FF41H, resets 00H
// - mode control enables counters, sets mode
// - cascade run controlled by enable one
// - output control sets level, inversion, enable
// - level set/reset bits read zero
// - port direction bitwise, resets FFH
// - mode bit 2 cascades counters
// - counter one overflow clocks counter two
// - cascaded match clears both, irq two
// - output toggles on every match while its invert bit is set
`timescale 1ns/1ps
module dual_timer import dual_timer_pkg::*; (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// cpu memory access
	input wire cpu_req_s i_req,
	output logic [15:0] o_rdata,
	output logic o_rd_valid,
	// oscillation mode bit from the system clock block
	input wire logic i_osc_div_select,
	// external event inputs
	input wire logic i_event_in_one,
	input wire logic i_event_in_two,
	// wave outputs, drive enable low while the pin is an output
	output logic o_wave_out_one,
	output logic o_wave_out_two,
	output logic o_wave_oe_n_one,
	output logic o_wave_oe_n_two,
	// interrupt requests, one-cycle pulses
	output logic o_match_irq_one,
	output logic o_match_irq_two
);
	// ==========================================================
	// state and decode
	// programmable registers
	logic [7:0] clk_sel_r;
	logic [7:0] mode_ctl_r;
	logic [7:0] out_ctl_r;
	logic [7:0] port_dir_r;
	logic [7:0] cmp_one_r;
	logic [7:0] cmp_two_r;
	// counters and output levels
	logic [7:0] count_one_r;
	logic [7:0] count_two_r;
	logic level_ff_one_r;
	logic level_ff_two_r;
	// count clock path
	logic [PRESCALE_BITS:1] tick;
	logic [2:0] ev_sync_r [2];
	logic [1:0] ev_rise;
	logic [1:0] ev_fall;
	logic step_one;
	logic step_two;
	// mode decode and compare path
	logic cascade_select;
	logic count_enable_one;
	logic count_enable_two;
	logic run_one;
	logic run_two;
	logic hit_one;
	logic hit_two;
	logic hit_both;
	logic match_one;
	logic match_two;
	// bus decode
	logic byte_wr;
	logic [7:0] rd_byte;

	// ==========================================================
	// prescaler
	// one divider serves both channels, so equal codes tick in step
	fxx_prescaler #(
		.BITS(PRESCALE_BITS)
	) u_prescaler (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_osc_div_select(i_osc_div_select),
		.o_tick(tick)
	);

	// ==========================================================
	// event input synchronisers; stage 0 feeds stage 1 only
	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_event
			always_ff @(posedge i_ref_clk) begin
				if (i_reset) begin
					ev_sync_r[c] <= 3'b000;
				end else begin
					ev_sync_r[c][0] <= (c == 0) ? i_event_in_one : i_event_in_two;
					ev_sync_r[c][2:1] <= ev_sync_r[c][1:0];
				end
			end
			assign ev_rise[c] = ev_sync_r[c][1] & ~ev_sync_r[c][2];
			assign ev_fall[c] = ~ev_sync_r[c][1] & ev_sync_r[c][2];
		end
	endgenerate

	// ==========================================================
	// count clock selection from one nibble; illegal codes give no tick
	// a prohibited code stalls the counter instead of guessing a rate
	function automatic logic pick_tick(input logic [3:0] code, input logic rise,
		input logic fall, input logic [PRESCALE_BITS:1] taps);
		logic r;
		r = 1'b0;
		if (code == CSEL_EDGE_FALL) begin
			r = fall;
		end else if (code == CSEL_EDGE_RISE) begin
			r = rise;
		end else if (code >= CSEL_DIV_FIRST && code <= CSEL_DIV_LAST) begin
			r = taps[code - CSEL_DIV_FIRST + 4'd1];
		end else if (code == CSEL_DIV_TOP) begin
			r = taps[DIV_TOP_EXP];
		end
		return r;
	endfunction

	assign step_one = pick_tick(clk_sel_r[3:0], ev_rise[0], ev_fall[0], tick);
	assign step_two = pick_tick(clk_sel_r[7:4], ev_rise[1], ev_fall[1], tick);

	// ==========================================================
	// run and match decode
	assign cascade_select = mode_ctl_r[MODE_CASCADE];
	assign count_enable_one = mode_ctl_r[MODE_ENABLE_ONE];
	assign count_enable_two = mode_ctl_r[MODE_ENABLE_TWO];
	// in cascade only the first enable matters
	assign run_one = count_enable_one & step_one;
	assign run_two = count_enable_two & step_two & ~cascade_select;
	assign hit_one = (count_one_r == cmp_one_r);
	assign hit_two = (count_two_r == cmp_two_r);
	assign hit_both = hit_one & hit_two;
	assign match_one = ~cascade_select & run_one & hit_one;
	assign match_two = cascade_select ? (run_one & hit_both) : (run_two & hit_two);

	// ==========================================================
	// counter one
	// a clear beats a step, so the matching tick restarts at zero
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			count_one_r <= RST_COUNT;
		end else if (match_one || (cascade_select && match_two)) begin
			count_one_r <= 8'h00;
		end else if (run_one) begin
			count_one_r <= count_one_r + 8'h01;
		end
	end

	// counter two; in cascade it steps on counter one wrapping
	// the carry looks at the old low byte, so the pair steps as one 16-bit count
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			count_two_r <= RST_COUNT;
		end else if (match_two) begin
			count_two_r <= 8'h00;
		end else if (cascade_select) begin
			if (run_one && count_one_r == 8'hFF) begin
				count_two_r <= count_two_r + 8'h01;
			end
		end else if (run_two) begin
			count_two_r <= count_two_r + 8'h01;
		end
	end

	// interrupt pulses, registered
	// registered so a compare write never leaves a glitch on the request
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_match_irq_one <= 1'b0;
			o_match_irq_two <= 1'b0;
		end else begin
			o_match_irq_one <= match_one;
			o_match_irq_two <= match_two;
		end
	end

	// ==========================================================
	// cpu writes: byte or single-bit; no register takes a word write
	assign byte_wr = i_req.wr & ~i_req.word & ~i_req.bit_op;

	function automatic logic [7:0] merge(input logic [7:0] old, input cpu_req_s q);
		logic [7:0] v;
		v = old;
		if (q.bit_op) begin
			v[q.bit_idx] = q.bit_val;
		end else begin
			v = q.wdata[7:0];
		end
		return v;
	endfunction

	// compare registers: no reset, so contents are undefined until written
	// word and bit writes are refused here, only whole bytes land
	always_ff @(posedge i_ref_clk) begin
		if (byte_wr && i_req.addr == ADDR_CMP_ONE) begin
			cmp_one_r <= i_req.wdata[7:0];
		end
		if (byte_wr && i_req.addr == ADDR_CMP_TWO) begin
			cmp_two_r <= i_req.wdata[7:0];
		end
	end

	// clock select: byte writes only
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			clk_sel_r <= RST_CLK_SEL;
		end else if (byte_wr && i_req.addr == ADDR_CLK_SEL) begin
			clk_sel_r <= i_req.wdata[7:0];
		end
	end

	// mode control and port direction: bit or byte writes
	// a bit write merges into the stored byte, neighbours keep their state
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			mode_ctl_r <= RST_MODE_CTL;
			port_dir_r <= RST_PORT_DIR;
		end else if (i_req.wr && !i_req.word) begin
			if (i_req.addr == ADDR_MODE_CTL) begin
				mode_ctl_r <= merge(mode_ctl_r, i_req);
			end
			if (i_req.addr == ADDR_PORT_DIR) begin
				port_dir_r <= merge(port_dir_r, i_req);
			end
		end
	end

	// output control; level strobes are not stored
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			out_ctl_r <= RST_OUT_CTL;
		end else if (i_req.wr && !i_req.word && i_req.addr == ADDR_OUT_CTL) begin
			out_ctl_r <= merge(out_ctl_r, i_req) & OUT_CTL_RD_MASK;
		end
	end

	// ==========================================================
	// level flip-flops: a write strobe wins over a toggle the same cycle
	logic [7:0] out_wr_val;
	logic out_wr;
	assign out_wr = i_req.wr & ~i_req.word & (i_req.addr == ADDR_OUT_CTL);
	assign out_wr_val = merge(out_ctl_r, i_req);

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			level_ff_one_r <= 1'b0;
		end else if (out_wr && out_wr_val[OUT_LVL_SET_ONE]) begin
			level_ff_one_r <= 1'b1;
		end else if (out_wr && out_wr_val[OUT_LVL_RESET_ONE]) begin
			level_ff_one_r <= 1'b0;
		end else if (match_one && out_ctl_r[OUT_INVERT_ONE]) begin
			level_ff_one_r <= ~level_ff_one_r;
		end
	end

	// channel two: same priorities, its own strobes
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			level_ff_two_r <= 1'b0;
		end else if (out_wr && out_wr_val[OUT_LVL_SET_TWO]) begin
			level_ff_two_r <= 1'b1;
		end else if (out_wr && out_wr_val[OUT_LVL_RESET_TWO]) begin
			level_ff_two_r <= 1'b0;
		end else if (match_two && out_ctl_r[OUT_INVERT_TWO]) begin
			level_ff_two_r <= ~level_ff_two_r;
		end
	end

	// pin drive: the level shows only with output enabled
	// the port output latch lives outside this block; only direction is seen here
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_wave_out_one <= 1'b0;
			o_wave_out_two <= 1'b0;
			o_wave_oe_n_one <= 1'b1;
			o_wave_oe_n_two <= 1'b1;
		end else begin
			o_wave_out_one <= out_ctl_r[OUT_ENABLE_ONE] & level_ff_one_r;
			o_wave_out_two <= out_ctl_r[OUT_ENABLE_TWO] & level_ff_two_r;
			o_wave_oe_n_one <= port_dir_r[DIR_PIN_ONE];
			o_wave_oe_n_two <= port_dir_r[DIR_PIN_TWO];
		end
	end

	// ==========================================================
	// reads: one cycle later; unmapped addresses return zero
	// the mux follows the address alone; the read strobe gates the capture below
	always_comb begin
		rd_byte = 8'h00;
		unique case (i_req.addr)
			ADDR_COUNT_ONE: rd_byte = count_one_r;
			ADDR_COUNT_TWO: rd_byte = count_two_r;
			ADDR_CMP_ONE: rd_byte = cmp_one_r;
			ADDR_CMP_TWO: rd_byte = cmp_two_r;
			ADDR_CLK_SEL: rd_byte = clk_sel_r;
			ADDR_MODE_CTL: rd_byte = mode_ctl_r;
			ADDR_OUT_CTL: rd_byte = out_ctl_r & OUT_CTL_RD_MASK;
			ADDR_PORT_DIR: rd_byte = port_dir_r;
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_rdata <= 16'h0000;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_req.rd;
			if (i_req.rd && i_req.word) begin
				// only the cascaded counter pair answers a word read
				if (cascade_select && i_req.addr == ADDR_COUNT_ONE) begin
					o_rdata <= {count_two_r, count_one_r};
				end else begin
					o_rdata <= 16'h0000;
				end
			end else if (i_req.rd) begin
				o_rdata <= {8'h00, rd_byte};
			end
		end
	end
endmodule // dual_timer

/* File: bench/dual_timer_sva.sv */
// Purpose: port-level checker for the dual 8-bit timer/event counter
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to every dual_timer instance at the foot of this file
`timescale 1ns/1ps
module dual_timer_sva import dual_timer_pkg::*; (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// cpu access
	input wire cpu_req_s i_req,
	input wire logic [15:0] o_rdata,
	input wire logic o_rd_valid,
	// pins
	input wire logic i_osc_div_select,
	input wire logic i_event_in_one,
	input wire logic i_event_in_two,
	input wire logic o_wave_out_one,
	input wire logic o_wave_out_two,
	input wire logic o_wave_oe_n_one,
	input wire logic o_wave_oe_n_two,
	input wire logic o_match_irq_one,
	input wire logic o_match_irq_two
);
	// ======================================================
	// assertions, all on the one clock
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);

	AST_RD_ANSWER: assert property (i_req.rd |=> o_rd_valid)
		else $error("read without answer one cycle later");
	AST_RD_NO_SPURIOUS: assert property (!i_req.rd |=> !o_rd_valid)
		else $error("read valid without a read");
	AST_RDATA_HOLD: assert property (!$past(i_req.rd) |-> $stable(o_rdata))
		else $error("read data moved without a read");
	// fastest tick is every second cycle, so a match pulse never repeats at once
	AST_IRQ_ONE_PULSE: assert property (o_match_irq_one |=> !o_match_irq_one)
		else $error("match one pulse longer than one cycle");
	AST_IRQ_TWO_PULSE: assert property (o_match_irq_two |=> !o_match_irq_two)
		else $error("match two pulse longer than one cycle");
	AST_RESET_QUIET: assert property (disable iff (1'b0) i_reset |=> !o_match_irq_one
		&& !o_match_irq_two && !o_rd_valid && o_wave_oe_n_one && o_wave_oe_n_two && !o_wave_out_one)
		else $error("outputs not at reset levels");
	AST_OE_HOLD: assert property (!$past(i_req.wr) && !$past(i_req.wr, 2) |->
		$stable(o_wave_oe_n_one) && $stable(o_wave_oe_n_two))
		else $error("pin direction moved without a write");
	AST_WAVE_CAUSE: assert property ($changed(o_wave_out_one) |-> $past(o_match_irq_one)
		|| $past(o_match_irq_one, 2) || $past(i_req.wr) || $past(i_req.wr, 2) || $past(i_req.wr, 3))
		else $error("wave one moved without match or write");

	// ======================================================
	// main scenarios reached
	cover property (o_match_irq_one);
	cover property (o_match_irq_two);
	cover property (i_req.rd && i_req.word);
endmodule // dual_timer_sva

bind dual_timer dual_timer_sva CHK (.i_ref_clk, .i_reset, .i_req, .o_rdata, .o_rd_valid,
	.i_osc_div_select, .i_event_in_one, .i_event_in_two, .o_wave_out_one, .o_wave_out_two,
	.o_wave_oe_n_one, .o_wave_oe_n_two, .o_match_irq_one, .o_match_irq_two);

/* File: bench/event_source.sv */
// Purpose: far-side model, external event pulses and pulled-up wave pin
// Assumes: pulses are slow enough for a two-stage synchroniser
// Notes: event line idles low between bursts
`timescale 1ns/1ps
module event_source (
	// clock
	input wire logic i_ref_clk,
	// wave pin as driven by the timer
	input wire logic i_wave,
	input wire logic i_wave_oe_n,
	// event line and resolved pin level
	output logic o_event,
	output logic o_pin
);
	// ======================================================
	// pin pulled high while the timer leaves it undriven
	assign o_pin = i_wave_oe_n ? 1'b1 : i_wave;
	initial o_event = 1'b0;

	// three cycles high, three low: each pulse gives one rise and one fall
	task automatic pulses(input int n);
		repeat (n) begin
			repeat (3) @(negedge i_ref_clk);
			o_event = 1'b1;
			repeat (3) @(negedge i_ref_clk);
			o_event = 1'b0;
		end
	endtask
endmodule // event_source

/* File: bench/dual_timer_test.sv */
// Purpose: self-checking bench for the dual 8-bit timer/event counter
// Assumes: one-cycle cpu strobes driven on the falling edge
// Notes: reset between interval runs clears leftover counts
`timescale 1ns/1ps
module dual_timer_test import dual_timer_pkg::*;;
	// ======================================================
	// signals
	logic i_ref_clk, i_reset, osc, ev1, ev2, rdv, w1, w2, oe1, oe2, irq1, irq2, pin1, pin2, p;
	cpu_req_s req;
	logic [15:0] rdata;
	int num_errors = 0;
	int checked = 0;
	int n, k;
	int ones = 0;
	logic [15:0] ra[7] = '{ADDR_CLK_SEL, ADDR_MODE_CTL, ADDR_OUT_CTL, ADDR_PORT_DIR,
		ADDR_COUNT_ONE, ADDR_COUNT_TWO, 16'hFF00};
	logic [15:0] rv[7] = '{16'h0000, 16'h0000, 16'h0000, 16'h00FF, 16'h0000, 16'h0000, 16'h0000};

	dual_timer DUT (.i_ref_clk, .i_reset, .i_req(req), .o_rdata(rdata), .o_rd_valid(rdv),
		.i_osc_div_select(osc), .i_event_in_one(ev1), .i_event_in_two(ev2),
		.o_wave_out_one(w1), .o_wave_out_two(w2), .o_wave_oe_n_one(oe1), .o_wave_oe_n_two(oe2),
		.o_match_irq_one(irq1), .o_match_irq_two(irq2));
	event_source SRC1 (.i_ref_clk, .i_wave(w1), .i_wave_oe_n(oe1), .o_event(ev1), .o_pin(pin1));
	event_source SRC2 (.i_ref_clk, .i_wave(w2), .i_wave_oe_n(oe2), .o_event(ev2), .o_pin(pin2));

	// 40 MHz clock; match one pulses counted for the cascade check
	initial i_ref_clk = 1'b0;
	always #12.5 i_ref_clk = ~i_ref_clk;
	always @(negedge i_ref_clk) if (irq1 === 1'b1) ones++;

	// ======================================================
	// tasks
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// one request for one cycle, released before the next is raised
	task automatic put(input logic [15:0] a, input logic r, w, wd, b, input logic [2:0] bi,
		input logic bv, input logic [15:0] d);
		@(negedge i_ref_clk);
		req = '{a, r, w, wd, b, bi, bv, d};
		@(negedge i_ref_clk);
		req = '0;
	endtask
	task automatic wr8(input logic [15:0] a, input logic [7:0] d);
		put(a, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0, {8'h00, d});
	endtask
	task automatic wrbit(input logic [15:0] a, input logic [2:0] i, input logic v);
		put(a, 1'b0, 1'b1, 1'b0, 1'b1, i, v, 16'h0000);
	endtask
	task automatic rd(input logic [15:0] a, input logic wd, input logic [15:0] exp);
		put(a, 1'b1, 1'b0, wd, 1'b0, 3'h0, 1'b0, 16'h0000);
		chk("read valid", {15'h0000, rdv}, 16'h0001);
		chk($sformatf("read %h", a), rdata, exp);
	endtask
	task automatic rst();
		@(negedge i_ref_clk);
		i_reset = 1'b1;
		repeat (2) @(negedge i_ref_clk);
		i_reset = 1'b0;
	endtask
	// cycles up to the next match pulse of one channel
	task automatic span(input logic two);
		n = 0;
		do begin
			@(negedge i_ref_clk);
			n++;
		end while ((two ? irq2 : irq1) !== 1'b1 && n < 20000);
		if (n >= 20000) begin
			num_errors++;
			$display("unexpected timeout waiting for a match");
			results();
		end
	endtask

	// ======================================================
	// tests
	initial begin
		i_reset = 1'b1;
		req = '0;
		osc = 1'b1;
		repeat (2) @(negedge i_ref_clk);
		i_reset = 1'b0;
		for (int i = 0; i < 7; i++) rd(ra[i], 1'b0, rv[i]);
		wr8(ADDR_CMP_ONE, 8'h5A);
		put(ADDR_CMP_ONE, 1'b0, 1'b1, 1'b1, 1'b0, 3'h0, 1'b0, 16'h1234);
		rd(ADDR_CMP_ONE, 1'b0, 16'h005A);
		wr8(ADDR_CLK_SEL, 8'h76);
		wrbit(ADDR_CLK_SEL, 3'h0, 1'b1);
		rd(ADDR_CLK_SEL, 1'b0, 16'h0076);
		wr8(ADDR_OUT_CTL, 8'hFF);
		rd(ADDR_OUT_CTL, 1'b0, 16'h0033);
		$display("registers done");
		// every divider clock code, 6H to FH, on both channels
		wr8(ADDR_CMP_ONE, 8'h01);
		wr8(ADDR_CMP_TWO, 8'h02);
		for (int c = 6; c < 16; c++) begin
			rst();
			k = (c == 15) ? 11 : c - 5;
			wr8(ADDR_CLK_SEL, {c[3:0], c[3:0]});
			wr8(ADDR_MODE_CTL, 8'h03);
			span(1'b0);
			span(1'b0);
			chk("interval one", 16'(n), 16'(2 << k));
			span(1'b1);
			span(1'b1);
			chk("interval two", 16'(n), 16'(3 << k));
		end
		// half base rate doubles the tick period
		osc = 1'b0;
		rst();
		wr8(ADDR_CLK_SEL, 8'h66);
		wrbit(ADDR_MODE_CTL, 3'(MODE_ENABLE_ONE), 1'b1);
		span(1'b0);
		span(1'b0);
		chk("half rate interval", 16'(n), 16'h0008);
		osc = 1'b1;
		rst();
		wr8(ADDR_CLK_SEL, 8'h22);
		wr8(ADDR_MODE_CTL, 8'h03);
		repeat (64) @(negedge i_ref_clk);
		rd(ADDR_COUNT_ONE, 1'b0, 16'h0000);
		$display("intervals done");
		// event edges: rising for one, falling for two, then stopped
		rst();
		wr8(ADDR_CMP_ONE, 8'hFF);
		wr8(ADDR_CMP_TWO, 8'hFF);
		wr8(ADDR_CLK_SEL, 8'h01);
		wr8(ADDR_MODE_CTL, 8'h03);
		fork
			SRC1.pulses(5);
			SRC2.pulses(5);
		join
		repeat (4) @(negedge i_ref_clk);
		rd(ADDR_COUNT_ONE, 1'b0, 16'h0005);
		rd(ADDR_COUNT_TWO, 1'b0, 16'h0005);
		wr8(ADDR_MODE_CTL, 8'h00);
		SRC1.pulses(3);
		rd(ADDR_COUNT_ONE, 1'b0, 16'h0005);
		$display("events done");
		// cascade: enable two alone does nothing, carry reaches the high byte
		rst();
		wr8(ADDR_MODE_CTL, 8'h06);
		SRC1.pulses(4);
		rd(ADDR_COUNT_ONE, 1'b1, 16'h0000);
		wr8(ADDR_MODE_CTL, 8'h05);
		SRC1.pulses(258);
		repeat (4) @(negedge i_ref_clk);
		rd(ADDR_COUNT_ONE, 1'b1, 16'h0102);
		rst();
		wr8(ADDR_CMP_ONE, 8'h03);
		wr8(ADDR_CMP_TWO, 8'h01);
		wr8(ADDR_CLK_SEL, 8'h06);
		wr8(ADDR_MODE_CTL, 8'h05);
		k = ones;
		span(1'b1);
		span(1'b1);
		chk("cascade interval", 16'(n), 16'd520);
		chk("match one quiet", 16'(ones), 16'(k));
		$display("cascade done");
		// wave pins: set levels, reset level two, toggle on each match, then reset mid-run
		rst();
		wr8(ADDR_PORT_DIR, 8'hF9);
		wr8(ADDR_CMP_ONE, 8'h03);
		wr8(ADDR_CLK_SEL, 8'h66);
		wr8(ADDR_OUT_CTL, 8'hBB);
		repeat (2) @(negedge i_ref_clk);
		chk("pin one set", {15'h0000, pin1}, 16'h0001);
		chk("pin two set", {14'h0000, oe2, pin2}, 16'h0001);
		wrbit(ADDR_OUT_CTL, 3'(OUT_LVL_RESET_TWO), 1'b1);
		repeat (2) @(negedge i_ref_clk);
		chk("pin two reset", {15'h0000, pin2}, 16'h0000);
		rd(ADDR_OUT_CTL, 1'b0, 16'h0033);
		wrbit(ADDR_MODE_CTL, 3'(MODE_ENABLE_ONE), 1'b1);
		wrbit(ADDR_MODE_CTL, 3'(MODE_ENABLE_TWO), 1'b1);
		span(1'b0);
		repeat (2) @(negedge i_ref_clk);
		p = pin1;
		span(1'b0);
		repeat (2) @(negedge i_ref_clk);
		chk("pin one toggle", {15'h0000, pin1}, {15'h0000, ~p});
		span(1'b1);
		repeat (2) @(negedge i_ref_clk);
		p = pin2;
		span(1'b1);
		repeat (2) @(negedge i_ref_clk);
		chk("pin two toggle", {15'h0000, pin2}, {15'h0000, ~p});
		rst();
		chk("pins released", {12'h000, oe2, w2, oe1, w1}, 16'h000A);
		rd(ADDR_MODE_CTL, 1'b0, 16'h0000);
		$display("outputs done");
		results();
	end
endmodule // dual_timer_test
